// ===== ref_pkg.sv
/*
 * ref_pkg: shared constants of the earth-fault decision stage.
 * Assumes a 32-bit AXI4-Lite register bus, one word per register.
 */
package ref_pkg;
  localparam int AXI_AW = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PRI     = 8'h04;
  localparam logic [7:0] OFS_NEUT    = 8'h08;
  localparam logic [7:0] OFS_BASE    = 8'h0C;
  localparam logic [7:0] OFS_SLOPE   = 8'h10;
  localparam logic [7:0] OFS_BRK     = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_DIFF    = 8'h1C;
  localparam logic [7:0] OFS_BIAS    = 8'h20;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h24;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h28;
  // control field positions
  localparam int CTRL_OPER_BIT = 0;
  localparam int CTRL_DIRC_BIT = 1;
  // status / interrupt field positions
  localparam int ST_TRIP_BIT  = 0;
  localparam int ST_DIR_BIT   = 1;
  localparam int ST_CHAR_BIT  = 2;
  localparam int ST_BLK_BIT   = 3;
  localparam int IRQ_TRIP_BIT = 0;
  localparam int IRQ_BLK_BIT  = 1;
  // setting ranges and reset values, percent
  localparam logic [9:0] PRI_MIN   = 10'h014;
  localparam logic [9:0] PRI_MAX   = 10'h1F4;
  localparam logic [9:0] PRI_RST   = 10'h064;
  localparam logic [9:0] NEUT_MIN  = 10'h064;
  localparam logic [9:0] NEUT_MAX  = 10'h3E8;
  localparam logic [9:0] NEUT_RST  = 10'h1F4;
  localparam logic [9:0] BASE_MIN  = 10'h00A;
  localparam logic [9:0] BASE_MAX  = 10'h032;
  localparam logic [9:0] BASE_RST  = 10'h01E;
  localparam logic [9:0] SLOPE_MIN = 10'h032;
  localparam logic [9:0] SLOPE_MAX = 10'h064;
  localparam logic [9:0] SLOPE_RST = 10'h046;
  localparam logic [9:0] BRK_MIN   = 10'h064;
  localparam logic [9:0] BRK_MAX   = 10'h0C8;
  localparam logic [9:0] BRK_RST   = 10'h07D;
  localparam logic       OPER_RST  = 1'b1;
  localparam logic       DIRC_RST  = 1'b1;
  localparam int         SENS_BOOST_SHIFT = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ref_pkg

// ===== ref_max4.sv
/*
 * ref_max4: largest of four unsigned magnitudes, registered.
 * Assumes inputs synchronous to aclk.
 */
`timescale 1ns/1ps
module ref_max4 #(
  parameter int W = 16
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] in_a,
  input  wire logic [W-1:0] in_b,
  input  wire logic [W-1:0] in_c,
  input  wire logic [W-1:0] in_d,
  output logic      [W-1:0] max_out
);
  typedef struct packed {
    logic [W-1:0] mx;
  } ref_max_s;

  ref_max_s st;
  ref_max_s next_st;
  logic [W-1:0] ab;
  logic [W-1:0] cd;

  always_comb begin
    ab        = (in_a > in_b) ? in_a : in_b;
    cd        = (in_c > in_d) ? in_c : in_d;
    next_st.mx = (ab > cd) ? ab : cd;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign max_out = st.mx;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_max_bound: assert property (
    aresetn |=> (max_out >= $past(in_a) && max_out >= $past(in_b)
         && max_out >= $past(in_c) && max_out >= $past(in_d)))
    else $error("bias below one of its inputs");
  a_max_member: assert property (
    aresetn |=> (max_out == $past(in_a) || max_out == $past(in_b)
         || max_out == $past(in_c) || max_out == $past(in_d)))
    else $error("bias not one of its inputs");
endmodule : ref_max4

// ===== ref_trip_decision_logic.sv
/*
 * ref_trip_decision_logic: trip decision of a restricted earth-fault
 * function with AXI4-Lite settings, measured values and interrupt.
 * Assumes upstream stages deliver the characteristic trip, the
 * directional flag and magnitudes synchronous to aclk.
 */
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
// How it works
// - trip only when above characteristic, not blocked and operation on
// - blocked when directional check on and flag set, or user block
// - operation setting Off/On, reset On; Off suppresses trip
// - directional check setting, reset true, gates directional blocking
// - boost input makes base sensitivity four times finer
// - compensation settings: primary 20..500 reset 100, neutral 100..1000 reset 500
// - slope setting 50..100 percent in steps of one
// - breakpoint 100..200 reset 125, base 30, slope 70
// - directional flag passed out unchanged beside the trip
// - one general trip output bit
// - no timer in the decision path
// - differential current readable in percent
// - bias current readable in percent
// - bias is the largest of phase and neutral magnitudes
`timescale 1ns/1ps
module ref_trip_decision_logic #(
  parameter int MAG_W = 16
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [ref_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [ref_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       char_internal_trip,
  input  wire logic                       dir_block_flag,
  input  wire logic                       user_block_in,
  input  wire logic                       sens_boost_in,
  input  wire logic [MAG_W-1:0]           phase_l1_mag,
  input  wire logic [MAG_W-1:0]           phase_l2_mag,
  input  wire logic [MAG_W-1:0]           phase_l3_mag,
  input  wire logic [MAG_W-1:0]           neutral_mag,
  input  wire logic [MAG_W-1:0]           diff_mag,
  output logic                            general_trip_out,
  output logic                            dir_block_out,
  output logic [9:0]                      primary_comp_pct,
  output logic [9:0]                      neutral_comp_pct,
  output logic [11:0]                     base_sens_qpct,
  output logic [9:0]                      slope_pct,
  output logic [9:0]                      breakpoint_pct,
  output logic                            irq
);
  if (MAG_W < 8 || MAG_W > 32) begin : g_chk
    $error("MAG_W must lie in 8..32");
  end

  typedef struct packed {
    logic             oper;
    logic             dir_chk;
    logic [9:0]       pri;
    logic [9:0]       neut;
    logic [9:0]       base;
    logic [9:0]       slope;
    logic [9:0]       brk;
    logic             trip;
    logic             dir;
    logic             blk;
    logic [MAG_W-1:0] diff;
    logic [1:0]       ist;
    logic [1:0]       imsk;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } ref_state_s;

  ref_state_s       st;
  ref_state_s       next_st;
  logic [MAG_W-1:0] bias;
  logic             wr_go;
  logic             rd_go;
  logic             blocked;
  logic [9:0]       wval;
  logic [31:0]      rword;
  logic             rhit;

  ref_max4 #(.W(MAG_W)) u_bias (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_a    (phase_l1_mag),
    .in_b    (phase_l2_mag),
    .in_c    (phase_l3_mag),
    .in_d    (neutral_mag),
    .max_out (bias)
  );

  // write address and data are taken together, one write in flight
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !st.bvalid;
  assign rd_go         = s_axi_arvalid && !st.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  assign blocked = (st.dir_chk && dir_block_flag) || user_block_in;

  // byte lanes 0 and 1 merge into a 10-bit setting
  function automatic logic [9:0] merge10(input logic [9:0]  old,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
    logic [15:0] v;
    v = {6'h00, old};
    if (be[0]) begin
      v[7:0] = d[7:0];
    end
    if (be[1]) begin
      v[15:8] = d[15:8];
    end
    merge10 = v[9:0];
  endfunction : merge10

  function automatic logic in_rng(input logic [9:0] v,
                                  input logic [9:0] lo,
                                  input logic [9:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction : in_rng

  always_comb begin
    rhit  = 1'b1;
    rword = 32'h0000_0000;
    case (s_axi_araddr)
      ref_pkg::OFS_CTRL: begin
        rword[ref_pkg::CTRL_OPER_BIT] = st.oper;
        rword[ref_pkg::CTRL_DIRC_BIT] = st.dir_chk;
      end
      ref_pkg::OFS_PRI:     rword[9:0] = st.pri;
      ref_pkg::OFS_NEUT:    rword[9:0] = st.neut;
      ref_pkg::OFS_BASE:    rword[9:0] = st.base;
      ref_pkg::OFS_SLOPE:   rword[9:0] = st.slope;
      ref_pkg::OFS_BRK:     rword[9:0] = st.brk;
      ref_pkg::OFS_STATUS: begin
        rword[ref_pkg::ST_TRIP_BIT] = st.trip;
        rword[ref_pkg::ST_DIR_BIT]  = st.dir;
        rword[ref_pkg::ST_CHAR_BIT] = char_internal_trip;
        rword[ref_pkg::ST_BLK_BIT]  = st.blk;
      end
      ref_pkg::OFS_DIFF:    rword[MAG_W-1:0] = st.diff;
      ref_pkg::OFS_BIAS:    rword[MAG_W-1:0] = bias;
      ref_pkg::OFS_IRQ_ST:  rword[1:0] = st.ist;
      ref_pkg::OFS_IRQ_MSK: rword[1:0] = st.imsk;
      default:              rhit = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    wval    = 10'h000;
    next_st.trip = char_internal_trip && !blocked && st.oper;
    next_st.dir  = dir_block_flag;
    next_st.blk  = blocked;
    next_st.diff = diff_mag;

    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    if (wr_go) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = ref_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        ref_pkg::OFS_CTRL: begin
          if (s_axi_wstrb[0]) begin
            next_st.oper    = s_axi_wdata[ref_pkg::CTRL_OPER_BIT];
            next_st.dir_chk = s_axi_wdata[ref_pkg::CTRL_DIRC_BIT];
          end
        end
        ref_pkg::OFS_PRI: begin
          wval = merge10(st.pri, s_axi_wdata, s_axi_wstrb);
          if (in_rng(wval, ref_pkg::PRI_MIN, ref_pkg::PRI_MAX)) begin
            next_st.pri = wval;
          end else begin
            next_st.bresp = ref_pkg::RESP_SLVERR;
          end
        end
        ref_pkg::OFS_NEUT: begin
          wval = merge10(st.neut, s_axi_wdata, s_axi_wstrb);
          if (in_rng(wval, ref_pkg::NEUT_MIN, ref_pkg::NEUT_MAX)) begin
            next_st.neut = wval;
          end else begin
            next_st.bresp = ref_pkg::RESP_SLVERR;
          end
        end
        ref_pkg::OFS_BASE: begin
          wval = merge10(st.base, s_axi_wdata, s_axi_wstrb);
          if (in_rng(wval, ref_pkg::BASE_MIN, ref_pkg::BASE_MAX)) begin
            next_st.base = wval;
          end else begin
            next_st.bresp = ref_pkg::RESP_SLVERR;
          end
        end
        ref_pkg::OFS_SLOPE: begin
          wval = merge10(st.slope, s_axi_wdata, s_axi_wstrb);
          if (in_rng(wval, ref_pkg::SLOPE_MIN, ref_pkg::SLOPE_MAX)) begin
            next_st.slope = wval;
          end else begin
            next_st.bresp = ref_pkg::RESP_SLVERR;
          end
        end
        ref_pkg::OFS_BRK: begin
          wval = merge10(st.brk, s_axi_wdata, s_axi_wstrb);
          if (in_rng(wval, ref_pkg::BRK_MIN, ref_pkg::BRK_MAX)) begin
            next_st.brk = wval;
          end else begin
            next_st.bresp = ref_pkg::RESP_SLVERR;
          end
        end
        ref_pkg::OFS_STATUS, ref_pkg::OFS_DIFF, ref_pkg::OFS_BIAS: begin
          // read-only words, writes ignored
        end
        ref_pkg::OFS_IRQ_ST: begin
          if (s_axi_wstrb[0]) begin
            next_st.ist = st.ist & ~s_axi_wdata[1:0];
          end
        end
        ref_pkg::OFS_IRQ_MSK: begin
          if (s_axi_wstrb[0]) begin
            next_st.imsk = s_axi_wdata[1:0];
          end
        end
        default: next_st.bresp = ref_pkg::RESP_SLVERR;
      endcase
    end

    // events are applied after the clear so a same-cycle event survives
    if (next_st.trip && !st.trip) begin
      next_st.ist[ref_pkg::IRQ_TRIP_BIT] = 1'b1;
    end
    if (blocked && !st.blk) begin
      next_st.ist[ref_pkg::IRQ_BLK_BIT] = 1'b1;
    end

    if (rd_go) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rword;
      next_st.rresp  = rhit ? ref_pkg::RESP_OKAY : ref_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.oper    <= ref_pkg::OPER_RST;
      st.dir_chk <= ref_pkg::DIRC_RST;
      st.pri     <= ref_pkg::PRI_RST;
      st.neut    <= ref_pkg::NEUT_RST;
      st.base    <= ref_pkg::BASE_RST;
      st.slope   <= ref_pkg::SLOPE_RST;
      st.brk     <= ref_pkg::BRK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign general_trip_out = st.trip;
  assign dir_block_out    = st.dir;
  assign primary_comp_pct = st.pri;
  assign neutral_comp_pct = st.neut;
  assign slope_pct        = st.slope;
  assign breakpoint_pct   = st.brk;
  // boost divides pickup
  // quarter-percent units keep the divide by four exact
  assign base_sens_qpct = sens_boost_in ? {2'b00, st.base}
                                        : {st.base, 2'b00};
  assign irq          = |(st.ist & st.imsk);
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp  = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp  = st.rresp;
  assign s_axi_rdata  = st.rdata;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_trip_cause: assert property (
    general_trip_out |-> $past(char_internal_trip) && $past(st.oper) && !$past(blocked))
    else $error("trip without all three conditions");
  a_trip_prompt: assert property (
    (aresetn && char_internal_trip && st.oper && !blocked) |=> general_trip_out)
    else $error("trip not raised one cycle after conditions");
  a_block_dir: assert property (
    (st.dir_chk && dir_block_flag) |=> !general_trip_out)
    else $error("directional block ignored");
  a_block_user: assert property (
    user_block_in |=> !general_trip_out)
    else $error("user block ignored");
  a_oper_off: assert property (
    !st.oper |=> !general_trip_out)
    else $error("trip while operation off");
  a_dir_pass: assert property (
    aresetn |=> dir_block_out == $past(dir_block_flag))
    else $error("directional flag not passed on");
  a_boost_scale: assert property (
    sens_boost_in |-> base_sens_qpct == {2'b00, st.base})
    else $error("boosted sensitivity wrong");
  a_diff_meas: assert property (
    aresetn |=> st.diff == $past(diff_mag))
    else $error("differential value not captured");
  a_range_pri: assert property (
    st.pri >= ref_pkg::PRI_MIN && st.pri <= ref_pkg::PRI_MAX)
    else $error("primary compensation out of range");
  a_range_slope: assert property (
    st.slope >= ref_pkg::SLOPE_MIN && st.slope <= ref_pkg::SLOPE_MAX)
    else $error("slope out of range");
  a_range_brk: assert property (
    st.brk >= ref_pkg::BRK_MIN && st.brk <= ref_pkg::BRK_MAX)
    else $error("breakpoint out of range");
  a_trip_flag: assert property (
    $rose(general_trip_out) |-> st.ist[ref_pkg::IRQ_TRIP_BIT])
    else $error("trip event lost");
  a_write_resp: assert property (
    wr_go |=> s_axi_bvalid)
    else $error("write without response");

  c_trip: cover property (char_internal_trip && st.oper && !blocked ##1 general_trip_out);
  c_dir_block: cover property (st.dir_chk && dir_block_flag && char_internal_trip);
  c_user_block: cover property (user_block_in && char_internal_trip);
  c_irq: cover property (irq);
endmodule : ref_trip_decision_logic

// ===== ref_upstream_model.sv
/*
 * ref_upstream_model: behavioural characteristic and directional stages
 * that feed the trip decision stage.
 * Assumes magnitudes, angle and settings are synchronous to aclk.
 */
`timescale 1ns/1ps
module ref_upstream_model (
  input  wire logic              aclk,
  input  wire logic              slow,
  input  wire logic signed [8:0] angle_deg,
  input  wire logic [15:0]       ph1,
  input  wire logic [15:0]       ph2,
  input  wire logic [15:0]       ph3,
  input  wire logic [15:0]       neut,
  input  wire logic [15:0]       diff,
  input  wire logic [11:0]       base_q,
  input  wire logic [9:0]        slope,
  input  wire logic [9:0]        brk,
  output logic                   char_internal_trip,
  output logic                   dir_block_flag
);
  logic [15:0] bias;
  logic [31:0] lim;
  logic        char_now;
  logic        dir_now;
  logic        char_d = 1'b0;
  logic        dir_d  = 1'b0;
  logic        char_q = 1'b0;
  logic        dir_q  = 1'b0;

  always_comb begin
    bias = ph1;
    if (ph2 > bias) bias = ph2;
    if (ph3 > bias) bias = ph3;
    if (neut > bias) bias = neut;
    lim = 32'(base_q);
    if (bias > 16'(brk)) lim = 32'(base_q) + ((32'(bias) - 32'(brk)) * 32'(slope) * 32'h4) / 32'h64;
    char_now = (32'({diff, 2'b00}) > lim);
    dir_now = (angle_deg > 9'sd90) || (angle_deg < -9'sd90);
  end

  // slow mode adds one stage, as a heavier upstream filter would
  always @(posedge aclk) begin
    char_d <= char_now;
    dir_d  <= dir_now;
    char_q <= char_d;
    dir_q  <= dir_d;
  end

  assign char_internal_trip = slow ? char_q : char_d;
  assign dir_block_flag     = slow ? dir_q : dir_d;
endmodule : ref_upstream_model

// ===== test_ref_trip_decision_logic.sv
/*
 * test_ref_trip_decision_logic: register, decision, interrupt and reset tests.
 * Assumes the upstream model drives the characteristic and direction inputs.
 */
`timescale 1ns/1ps
module test_ref_trip_decision_logic;
  logic              aclk = 1'b0;
  logic              aresetn, awvalid, wvalid, bready, arvalid, rready, user_blk, boost, slow;
  logic              awready, wready, bvalid, arready, rvalid, trip, dir_out, irq, char_trip, dir_flag;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [15:0]       ph1, ph2, ph3, neut, diff;
  logic signed [8:0] angle;
  logic [11:0]       base_q;
  logic [9:0]        pri, neu, slope, brk;
  int                miscompares = 0;
  int                cmp_count = 0;

  always #2.5 aclk = ~aclk;

  ref_trip_decision_logic uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .char_internal_trip(char_trip), .dir_block_flag(dir_flag), .user_block_in(user_blk),
    .sens_boost_in(boost), .phase_l1_mag(ph1), .phase_l2_mag(ph2), .phase_l3_mag(ph3),
    .neutral_mag(neut), .diff_mag(diff), .general_trip_out(trip), .dir_block_out(dir_out),
    .primary_comp_pct(pri), .neutral_comp_pct(neu), .base_sens_qpct(base_q), .slope_pct(slope),
    .breakpoint_pct(brk), .irq(irq)
  );

  ref_upstream_model up (
    .aclk(aclk), .slow(slow), .angle_deg(angle), .ph1(ph1), .ph2(ph2), .ph3(ph3), .neut(neut),
    .diff(diff), .base_q(base_q), .slope(slope), .brk(brk), .char_internal_trip(char_trip),
    .dir_block_flag(dir_flag)
  );

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp1(input logic got, input logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask : cmp1

  // a handshake that never comes ends the run
  task automatic guard(inout int n);
    n++;
    if (n > 50) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, 50);
      wrap_up();
    end
  endtask : guard

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask : cyc

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp32({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp32(rdata, ed);
    cmp32({30'h0, rresp}, {30'h0, er});
  endtask : axi_rd

  // both ends of a setting accepted, one step outside refused, value kept after the low-end refusal
  task automatic chk_rng(input logic [7:0] a, input logic [9:0] lo, input logic [9:0] hi);
    axi_wr(a, {22'h0, lo}, ref_pkg::RESP_OKAY);
    axi_wr(a, {22'h0, lo - 10'h1}, ref_pkg::RESP_SLVERR);
    axi_rd(a, {22'h0, lo}, ref_pkg::RESP_OKAY);
    axi_wr(a, {22'h0, hi + 10'h1}, ref_pkg::RESP_SLVERR);
    axi_wr(a, {22'h0, hi}, ref_pkg::RESP_OKAY);
    axi_rd(a, {22'h0, hi}, ref_pkg::RESP_OKAY);
  endtask : chk_rng

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; user_blk = 1'b0; boost = 1'b0; slow = 1'b0;
    ph1 = 16'h0010; ph2 = 16'h0010; ph3 = 16'h0010; neut = 16'h0010; diff = 16'h0000; angle = 9'sd0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    cmp1(trip, 1'b0);
    cmp32(32'(base_q), 32'h78);
    axi_rd(ref_pkg::OFS_CTRL, 32'h3, ref_pkg::RESP_OKAY);
    axi_rd(ref_pkg::OFS_PRI, 32'h64, ref_pkg::RESP_OKAY);
    axi_rd(ref_pkg::OFS_NEUT, 32'h1F4, ref_pkg::RESP_OKAY);
    axi_rd(ref_pkg::OFS_BASE, 32'h1E, ref_pkg::RESP_OKAY);
    axi_rd(ref_pkg::OFS_SLOPE, 32'h46, ref_pkg::RESP_OKAY);
    axi_rd(ref_pkg::OFS_BRK, 32'h7D, ref_pkg::RESP_OKAY);
    chk_rng(ref_pkg::OFS_PRI, 10'h014, 10'h1F4);
    chk_rng(ref_pkg::OFS_NEUT, 10'h064, 10'h3E8);
    chk_rng(ref_pkg::OFS_SLOPE, 10'h032, 10'h064);
    chk_rng(ref_pkg::OFS_BRK, 10'h064, 10'h0C8);
    chk_rng(ref_pkg::OFS_BASE, 10'h00A, 10'h032);
    cmp32({2'b00, pri, neu, slope}, {2'b00, 10'h1F4, 10'h3E8, 10'h064});
    cmp32({22'h0, brk}, {22'h0, 10'h0C8});
    axi_rd(8'h2C, 32'h0, ref_pkg::RESP_SLVERR);
    axi_wr(8'h2C, 32'h1, ref_pkg::RESP_SLVERR);
    diff <= 16'h0200;
    for (int i = 0; i < 16; i++) begin
      axi_wr(ref_pkg::OFS_CTRL, {30'h0, i[1], i[0]}, ref_pkg::RESP_OKAY);
      angle    <= i[2] ? 9'sd91 : 9'sd90;
      user_blk <= i[3];
      cyc(4);
      cmp1(trip, i[0] & ~((i[1] & i[2]) | i[3]));
      cmp1(dir_out, i[2]);
    end
    // trip one edge after the characteristic flag, prompt and slow upstream
    for (int s = 0; s < 2; s++) begin
      int n;
      n = 0;
      axi_wr(ref_pkg::OFS_CTRL, 32'h1, ref_pkg::RESP_OKAY);
      user_blk <= 1'b0;
      diff     <= 16'h0000;
      slow     <= s[0];
      cyc(4);
      cmp1(trip, 1'b0);
      @(posedge aclk);
      diff <= 16'h0200;
      do begin
        @(posedge aclk);
        guard(n);
      end while (char_trip !== 1'b1);
      #1;
      cmp1(trip, 1'b1);
    end
    axi_wr(ref_pkg::OFS_IRQ_ST, 32'h3, ref_pkg::RESP_OKAY);
    axi_wr(ref_pkg::OFS_IRQ_MSK, 32'h1, ref_pkg::RESP_OKAY);
    axi_rd(ref_pkg::OFS_IRQ_ST, 32'h0, ref_pkg::RESP_OKAY);
    cmp1(irq, 1'b0);
    diff <= 16'h0000;
    cyc(4);
    @(posedge aclk);
    diff <= 16'h0200;
    cyc(4);
    cmp1(irq, 1'b1);
    @(posedge aclk);
    user_blk <= 1'b1;
    cyc(3);
    axi_rd(ref_pkg::OFS_IRQ_ST, 32'h3, ref_pkg::RESP_OKAY);
    axi_rd(ref_pkg::OFS_STATUS, 32'hE, ref_pkg::RESP_OKAY);
    axi_wr(ref_pkg::OFS_STATUS, 32'hF, ref_pkg::RESP_OKAY);
    axi_rd(ref_pkg::OFS_STATUS, 32'hE, ref_pkg::RESP_OKAY);
    axi_wr(ref_pkg::OFS_IRQ_ST, 32'h1, ref_pkg::RESP_OKAY);
    cyc(1);
    cmp1(irq, 1'b0);
    axi_rd(ref_pkg::OFS_IRQ_ST, 32'h2, ref_pkg::RESP_OKAY);
    axi_wr(ref_pkg::OFS_IRQ_MSK, 32'h2, ref_pkg::RESP_OKAY);
    cyc(1);
    cmp1(irq, 1'b1);
    cmp32(32'(base_q), 32'hC8);
    @(posedge aclk);
    boost <= 1'b1;
    cyc(1);
    cmp32(32'(base_q), 32'h32);
    @(posedge aclk);
    ph1  <= 16'h000A;
    ph2  <= 16'h00C8;
    ph3  <= 16'h001E;
    neut <= 16'h0096;
    diff <= 16'h0123;
    cyc(3);
    axi_rd(ref_pkg::OFS_DIFF, 32'h123, ref_pkg::RESP_OKAY);
    axi_rd(ref_pkg::OFS_BIAS, 32'hC8, ref_pkg::RESP_OKAY);
    neut <= 16'h012C;
    cyc(3);
    axi_rd(ref_pkg::OFS_BIAS, 32'h12C, ref_pkg::RESP_OKAY);
    axi_wr(ref_pkg::OFS_CTRL, 32'h1, ref_pkg::RESP_OKAY);
    user_blk <= 1'b0;
    angle    <= 9'sd180;
    cyc(4);
    cmp1(trip, 1'b1);
    cmp1(dir_out, 1'b1);
    @(posedge aclk);
    aresetn <= 1'b0;
    cyc(1);
    cmp1(trip, 1'b0);
    cmp1(dir_out, 1'b0);
    cmp1(irq, 1'b0);
    @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ref_pkg::OFS_CTRL, 32'h3, ref_pkg::RESP_OKAY);
    cyc(4);
    cmp1(trip, 1'b0);
    cmp1(dir_out, 1'b1);
    wrap_up();
  end
endmodule : test_ref_trip_decision_logic
